// ---- common/dsis_pkg.sv ----
// dsis_pkg: constants of the converter start-up register block
// assumes 8-bit registers behind a 4-wire serial port with 7-bit address
package dsis_pkg;
  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [6:0] A_IFC = 7'h00;
  localparam logic [6:0] A_FSC_LO = 7'h06;
  localparam logic [6:0] A_FSC_HI = 7'h07;
  localparam logic [6:0] A_OPMODE = 7'h08;
  localparam logic [6:0] A_CEN = 7'h10;
  localparam logic [6:0] A_SKEW = 7'h13;
  localparam logic [6:0] A_DIVSEL = 7'h14;
  localparam logic [6:0] A_RXS = 7'h21;
  localparam logic [6:0] A_CM_A = 7'h22;
  localparam logic [6:0] A_CM_B = 7'h23;
  localparam logic [6:0] A_PT_A = 7'h24;
  localparam logic [6:0] A_PT_B = 7'h25;
  localparam logic [6:0] A_PT_CTL = 7'h26;
  localparam logic [6:0] A_PT_C = 7'h27;
  localparam logic [6:0] A_PT_D = 7'h28;
  localparam logic [6:0] A_PT_E = 7'h29;
  localparam logic [6:0] A_PTS = 7'h2A;
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_IFC = 8'h00;
  localparam logic [7:0] RST_FSC_LO = 8'h00;
  localparam logic [7:0] RST_FSC_HI = 8'h02;
  localparam logic [7:0] RST_OPMODE = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h00;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int IFC_SRST_HI = 5;
  localparam int IFC_SRST_LO = 2;
  localparam int IFC_LSB_HI = 6;
  localparam int IFC_LSB_LO = 1;
  localparam int CEN_TRACK = 0;
  localparam int CEN_LOOP = 1;
  localparam int PTC_TRACK = 0;
  localparam int PTC_EN = 1;
  localparam int RXS_LOCK = 0;
  localparam int RXS_TRACK = 3;
  localparam int PTS_LOCK = 0;
  localparam int DIVSEL_LO = 6;
  // ****************************************************************
  // timing and framing
  // ****************************************************************
  localparam logic [11:0] LOCK_CYC = 12'h3E8;
  localparam logic [5:0] DCLK_TMO = 6'h3F;
  localparam logic [4:0] INSTR_LAST = 5'h07;
  localparam logic [4:0] FRAME_LAST = 5'h0F;
  localparam logic [4:0] FRAME_DONE = 5'h10;

  function automatic logic [7:0] bit_rev(input logic [7:0] b);
    bit_rev = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
  endfunction
endpackage

// ---- common/dsis_reg_if.sv ----
// dsis_reg_if: serial port to register file carrier
// assumes both ends run on core_clk
`timescale 1ns/1ps
`default_nettype none
interface dsis_reg_if;
  logic wr_stb;
  logic rd_stb;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic lsb_first;
  modport port (output wr_stb, rd_stb, addr, wdata, input rdata, lsb_first);
  modport regs (input wr_stb, rd_stb, addr, wdata, output rdata, lsb_first);
endinterface
`default_nettype wire

// ---- verilog/dsis_spi_port.sv ----
// dsis_spi_port: 4-wire serial slave, instruction byte then data byte
// assumes sclk well below core_clk / 4; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module dsis_spi_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // register side
  dsis_reg_if.port rb
);
  import dsis_pkg::*;

  typedef struct packed {
    logic [2:0] sclk_p;
    logic [1:0] cs_p;
    logic [1:0] sdi_p;
    logic [4:0] cnt;
    logic [7:0] shin;
    logic [7:0] shout;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic sdo;
    logic sdo_oe;
  } dsis_spi_t;

  dsis_spi_t q;
  dsis_spi_t next_q;

  // ****************************************************************
  // frame engine
  // ****************************************************************
  always_comb begin
    logic [7:0] sh;
    logic [7:0] by;
    next_q = q;
    sh = {q.shin[6:0], q.sdi_p[1]};
    by = rb.lsb_first ? bit_rev(sh) : sh;
    next_q.sclk_p = {q.sclk_p[1:0], sclk};
    next_q.cs_p = {q.cs_p[0], cs_n};
    next_q.sdi_p = {q.sdi_p[0], sdi};
    next_q.wr_stb = 1'b0;
    next_q.rd_stb = 1'b0;
    // read data is fetched one cycle after the instruction byte
    if (q.rd_stb) begin
      next_q.shout = rb.lsb_first ? bit_rev(rb.rdata) : rb.rdata;
    end
    if (q.cs_p[1]) begin
      next_q.cnt = 5'h00;
      next_q.sdo_oe = 1'b0;
    end else if (q.sclk_p[1] && !q.sclk_p[2]) begin
      next_q.shin = sh;
      if (q.cnt != FRAME_DONE) begin
        next_q.cnt = q.cnt + 5'h01;
      end
      // [R01] instruction byte decode
      if (q.cnt == INSTR_LAST) begin
        next_q.rd = by[7];
        next_q.addr = by[6:0];
        next_q.rd_stb = by[7];
      end
      if (q.cnt == FRAME_LAST && !q.rd) begin
        next_q.wdata = by;
        next_q.wr_stb = 1'b1;
      end
    end else if (!q.sclk_p[1] && q.sclk_p[2] && q.rd && q.cnt[3] &&
                 !q.cnt[4]) begin
      next_q.sdo = q.shout[7];
      next_q.shout = {q.shout[6:0], 1'b0};
      next_q.sdo_oe = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.sclk_p <= 3'h0;
      q.cs_p <= 2'h3;
    end else begin
      q <= next_q;
    end
  end

  assign rb.wr_stb = q.wr_stb;
  assign rb.rd_stb = q.rd_stb;
  assign rb.addr = q.addr;
  assign rb.wdata = q.wdata;
  assign sdo = q.sdo;
  assign sdo_oe = q.sdo_oe;
endmodule
`default_nettype wire

// ---- verilog/dsis_lock_ctrl.sv ----
// dsis_lock_ctrl: search-then-track lock model of one controller
// assumes run and loop_ok are already on core_clk
`timescale 1ns/1ps
`default_nettype none
module dsis_lock_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic restart,
  input wire logic loop_ok,
  // status
  output logic locked,
  output logic tracking
);
  import dsis_pkg::*;

  typedef struct packed {
    logic [11:0] cnt;
    logic locked;
    logic tracking;
  } dsis_lock_t;

  dsis_lock_t q;
  dsis_lock_t next_q;

  always_comb begin
    next_q = q;
    if (!run || restart) begin
      next_q.cnt = 12'h000;
      next_q.locked = 1'b0;
      next_q.tracking = 1'b0;
    end else if (q.cnt != LOCK_CYC) begin
      next_q.cnt = q.cnt + 12'h001;
    end else begin
      // lock follows the loop once the search window is spent
      next_q.locked = loop_ok;
      if (loop_ok) begin
        next_q.tracking = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign locked = q.locked;
  assign tracking = q.tracking;
endmodule
`default_nettype wire

// ---- verilog/dsis_init_core.sv ----
// dsis_init_core: converter start-up register block and lock controllers
// assumes host drives the 4-wire serial port; status pins are asynchronous
//
// Operation
// [R01] host sets up the device only through serial port writes and reads
// [R02] soft reset optional; power-on and reset pin also restore defaults
// [R03] multichip sync controller programming is optional; not built here
// [R04] phase tracking must track before receive controller runs
// [R05] host limits lock attempts for each controller to three
// [R06] first write picks 4-wire msb-first; bits 7:5 mirror bits 2:0
// [R07] writing 0x20 to address 0 restores defaults; host then writes zero
// [R08] host writes 0x0F to both clock common-mode registers
// [R09] host loads phase tracking configuration in fixed order, control last
// [R10] control value 0x03 starts phase tracking search then track
// [R11] host waits 160K data periods before reading phase tracking status
// [R12] phase tracking status 0x01 means locked; host retries from config e
// [R13] data source must supply the input data clock before receive setup
// [R14] host writes 0x72 to the receive skew register, fine skew two
// [R15] enable register: interface_config off, 0x02 loop and interrupt, 0x03 track
// [R16] host waits 135K data periods before reading receive status
// [R17] receive status 0x09 is locked and tracking; else advance divider
// [R18] full-scale current registers optional; default gives 20 mA
// [R19] operation mode register optional; default is normal mode
// [R20] controller status may be watched by interrupt pin or polling
// [R21] with sync, host compares input clock delay values across devices
// [R22] host keeps sticky failure flag per controller, halts after third
`timescale 1ns/1ps
`default_nettype none
module dsis_init_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // serial port
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // converter status pins
  input wire logic input_data_clock,
  input wire logic phase_loop_ok,
  input wire logic rx_loop_ok,
  // converter settings
  output logic [9:0] full_scale_current_setting,
  output logic [7:0] converter_mode,
  output logic [1:0] divider_phase_select,
  // controller status
  output logic output_data_clock_en,
  output logic irq
);
  import dsis_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0] pok_p;
    logic [1:0] rok_p;
    logic [2:0] dclk_p;
    logic [5:0] dclk_tmo;
    logic dclk_seen;
    logic [7:0] ifc;
    logic [7:0] fsc_lo;
    logic [7:0] fsc_hi;
    logic [7:0] opmode;
    logic [7:0] cen;
    logic [7:0] skew;
    logic [7:0] divsel;
    logic [7:0] cm_a;
    logic [7:0] cm_b;
    logic [7:0] pt_a;
    logic [7:0] pt_b;
    logic [7:0] pt_ctl;
    logic [7:0] pt_c;
    logic [7:0] pt_d;
    logic [7:0] pt_e;
    logic pt_restart;
    logic rx_restart;
    logic odc_en;
    logic irq;
  } dsis_core_t;

  dsis_core_t q;
  dsis_core_t next_q;
  logic [1:0] rst_sync;
  logic rst_n;
  logic pt_locked;
  logic pt_tracking;
  logic rx_locked;
  logic rx_tracking;
  logic pt_run;
  logic rx_run;
  logic soft_rst;

  dsis_reg_if rb();

  // ****************************************************************
  // reset release
  // ****************************************************************
  // [R02] power-on reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ****************************************************************
  // register read
  // ****************************************************************
  function automatic logic [7:0] reg_read(
    input dsis_core_t s,
    input logic [6:0] a,
    input logic ptl,
    input logic rxl,
    input logic rxt
  );
    logic [7:0] v;
    v = 8'h00;
    case (a)
      A_IFC: v = s.ifc;
      A_FSC_LO: v = s.fsc_lo;
      A_FSC_HI: v = s.fsc_hi;
      A_OPMODE: v = s.opmode;
      A_CEN: v = s.cen;
      A_SKEW: v = s.skew;
      A_DIVSEL: v = s.divsel;
      A_CM_A: v = s.cm_a;
      A_CM_B: v = s.cm_b;
      A_PT_A: v = s.pt_a;
      A_PT_B: v = s.pt_b;
      A_PT_CTL: v = s.pt_ctl;
      A_PT_C: v = s.pt_c;
      A_PT_D: v = s.pt_d;
      A_PT_E: v = s.pt_e;
      // [R12] phase lock status
      A_PTS: v[PTS_LOCK] = ptl;
      // [R17] receive lock and track
      A_RXS: begin
        v[RXS_LOCK] = rxl;
        v[RXS_TRACK] = rxt;
      end
      default: v = 8'h00;
    endcase
    reg_read = v;
  endfunction

  // [R20] status readable by polling
  assign rb.rdata = reg_read(q, rb.addr, pt_locked, rx_locked, rx_tracking);
  // [R06] mirrored bit order field
  assign rb.lsb_first = q.ifc[IFC_LSB_HI] | q.ifc[IFC_LSB_LO];
  // [R07] soft reset bit, either mirror
  assign soft_rst = q.ifc[IFC_SRST_HI] | q.ifc[IFC_SRST_LO];

  // ****************************************************************
  // controller enables
  // ****************************************************************
  // [R10] both control bits start search
  assign pt_run = q.pt_ctl[PTC_EN] & q.pt_ctl[PTC_TRACK];
  // [R04] receive needs phase lock
  // [R13] and a live data clock
  // [R15] loop and track bits
  assign rx_run = q.cen[CEN_LOOP] & q.cen[CEN_TRACK] & pt_locked &
                  q.dclk_seen;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_q = q;
    next_q.pok_p = {q.pok_p[0], phase_loop_ok};
    next_q.rok_p = {q.rok_p[0], rx_loop_ok};
    next_q.dclk_p = {q.dclk_p[1:0], input_data_clock};
    // presence detect: any edge within the timeout window
    if (q.dclk_p[1] != q.dclk_p[2]) begin
      next_q.dclk_tmo = DCLK_TMO;
      next_q.dclk_seen = 1'b1;
    end else if (q.dclk_tmo != 6'h00) begin
      next_q.dclk_tmo = q.dclk_tmo - 6'h01;
    end else begin
      next_q.dclk_seen = 1'b0;
    end
    next_q.pt_restart = 1'b0;
    next_q.rx_restart = 1'b0;
    // [R01] register writes
    if (rb.wr_stb) begin
      case (rb.addr)
        A_IFC: next_q.ifc = rb.wdata;
        A_FSC_LO: next_q.fsc_lo = rb.wdata;
        A_FSC_HI: next_q.fsc_hi = rb.wdata;
        A_OPMODE: next_q.opmode = rb.wdata;
        A_CEN: next_q.cen = rb.wdata;
        A_SKEW: next_q.skew = rb.wdata;
        // [R17] new divider phase restarts receive search
        A_DIVSEL: begin
          next_q.divsel = rb.wdata;
          next_q.rx_restart = 1'b1;
        end
        A_CM_A: next_q.cm_a = rb.wdata;
        A_CM_B: next_q.cm_b = rb.wdata;
        A_PT_A: next_q.pt_a = rb.wdata;
        A_PT_B: next_q.pt_b = rb.wdata;
        A_PT_CTL: next_q.pt_ctl = rb.wdata;
        A_PT_C: next_q.pt_c = rb.wdata;
        A_PT_D: next_q.pt_d = rb.wdata;
        // [R12] retry point restarts phase search
        A_PT_E: begin
          next_q.pt_e = rb.wdata;
          next_q.pt_restart = 1'b1;
        end
        default: next_q.pt_restart = 1'b0;
      endcase
    end
    // [R07] hold defaults while reset bit set
    // the interface register itself survives so the host can clear it
    if (soft_rst) begin
      // [R18] default full-scale current
      next_q.fsc_lo = RST_FSC_LO;
      next_q.fsc_hi = RST_FSC_HI;
      // [R19] default normal mode
      next_q.opmode = RST_OPMODE;
      next_q.cen = RST_CFG;
      next_q.skew = RST_CFG;
      next_q.divsel = RST_CFG;
      next_q.cm_a = RST_CFG;
      next_q.cm_b = RST_CFG;
      next_q.pt_a = RST_CFG;
      next_q.pt_b = RST_CFG;
      next_q.pt_ctl = RST_CFG;
      next_q.pt_c = RST_CFG;
      next_q.pt_d = RST_CFG;
      next_q.pt_e = RST_CFG;
    end
    // [R04] output data clock follows phase tracking
    next_q.odc_en = pt_tracking;
    // [R20] interrupt when receive lock and loop enabled
    next_q.irq = q.cen[CEN_LOOP] & rx_locked;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.ifc <= RST_IFC;
      q.fsc_lo <= RST_FSC_LO;
      q.fsc_hi <= RST_FSC_HI;
      q.opmode <= RST_OPMODE;
    end else begin
      q <= next_q;
    end
  end

  // ****************************************************************
  // serial port and controllers
  // ****************************************************************
  dsis_spi_port u_spi (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .rb(rb.port)
  );

  dsis_lock_ctrl u_pt_lock (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(pt_run),
    .restart(q.pt_restart),
    .loop_ok(q.pok_p[1]),
    .locked(pt_locked),
    .tracking(pt_tracking)
  );

  dsis_lock_ctrl u_rx_lock (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(rx_run),
    .restart(q.rx_restart),
    .loop_ok(q.rok_p[1]),
    .locked(rx_locked),
    .tracking(rx_tracking)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  // [R18] current setting to the output stage
  assign full_scale_current_setting = {q.fsc_hi[1:0], q.fsc_lo};
  // [R19] operation mode to the converter core
  assign converter_mode = q.opmode;
  assign divider_phase_select = q.divsel[DIVSEL_LO+1:DIVSEL_LO];
  assign output_data_clock_en = q.odc_en;
  assign irq = q.irq;
endmodule
`default_nettype wire

// ---- testbench/dsis_init_core_assertions.sv ----
// dsis_init_core_assertions: port checks of the start-up register block
// assumes it is bound to dsis_init_core; one clock domain
`timescale 1ns/1ps
`default_nettype none
module dsis_init_core_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // serial port
  input wire logic cs_n,
  input wire logic sdo_oe,
  // status pins
  input wire logic input_data_clock,
  input wire logic phase_loop_ok,
  input wire logic rx_loop_ok,
  // settings and status outputs
  input wire logic [9:0] full_scale_current_setting,
  input wire logic [7:0] converter_mode,
  input wire logic output_data_clock_en,
  input wire logic irq
);
  logic [7:0] frame_age;
  logic [7:0] dclk_idle;
  logic dclk_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ****************************************************************
  // helper counters
  // ****************************************************************
  // frame_age: cycles since chip select was low; saturates, never wraps
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_age <= 8'hFF;
      dclk_idle <= 8'h00;
      dclk_q <= 1'b0;
    end else begin
      frame_age <= !cs_n ? 8'h00 : frame_age + {7'h00, frame_age != 8'hFF};
      dclk_q <= input_data_clock;
      dclk_idle <= (dclk_q != input_data_clock) ? 8'h00 :
        dclk_idle + {7'h00, dclk_idle != 8'hFF};
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  // defaults at release
  property p_rst_defaults;
    $rose(arst_n) |-> full_scale_current_setting == 10'h200 &&
      converter_mode == 8'h00 && !irq && !output_data_clock_en && !sdo_oe;
  endproperty
  a_rst_defaults: assert property (p_rst_defaults)
    else $error("outputs not at defaults after reset");
  property p_oe_in_frame;
    $rose(sdo_oe) |-> !cs_n;
  endproperty
  a_oe_in_frame: assert property (p_oe_in_frame)
    else $error("sdo enabled outside a frame");
  property p_oe_idle;
    cs_n [*6] |-> !sdo_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("sdo still enabled after chip select high");
  property p_irq_loop;
    !rx_loop_ok [*6] |-> !irq;
  endproperty
  a_irq_loop: assert property (p_irq_loop)
    else $error("irq high while receive loop cannot lock");
  property p_irq_dclk;
    dclk_idle >= 8'h50 |-> !irq;
  endproperty
  a_irq_dclk: assert property (p_irq_dclk)
    else $error("irq high without input data clock");
  property p_odc_loop;
    !phase_loop_ok [*6] |-> !$rose(output_data_clock_en);
  endproperty
  a_odc_loop: assert property (p_odc_loop)
    else $error("phase tracking began while loop cannot lock");
  property p_mode_by_write;
    $changed(converter_mode) |-> frame_age < 8'h0C;
  endproperty
  a_mode_by_write: assert property (p_mode_by_write)
    else $error("operation mode changed outside a write");
  property p_fsc_by_write;
    $changed(full_scale_current_setting) |-> frame_age < 8'h0C;
  endproperty
  a_fsc_by_write: assert property (p_fsc_by_write)
    else $error("full-scale current changed outside a write");
endmodule
`default_nettype wire

// ---- testbench/dsis_host_model.sv ----
// dsis_host_model: host processor side of the 4-wire serial port
// assumes pins change just after the falling edge of core_clk
`timescale 1ns/1ps
`default_nettype none
module dsis_host_model #(
  parameter int HALF = 4
) (
  // bench clock
  input wire logic core_clk,
  // serial pins
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // one frame: instruction then data
  // half period of 100 ns; sdo settles 3 core cycles after the fall
  task automatic xfer(input logic lsb, input logic rd, input logic [6:0] a,
                      input logic [7:0] wd, output logic [7:0] rv);
    logic [15:0] tx;
    int k;
    tx = {rd, a, wd};
    rv = 8'h00;
    @(negedge core_clk);
    cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      k = lsb ? ((i < 8) ? 8 : 0) + (i % 8) : 15 - i;
      sdi = tx[k];
      repeat (HALF) @(negedge core_clk);
      sclk = 1'b1;
      if (i >= 8) rv[k % 8] = sdo_oe ? sdo : 1'bx;
      repeat (HALF) @(negedge core_clk);
      sclk = 1'b0;
    end
    repeat (HALF) @(negedge core_clk);
    cs_n = 1'b1;
    // released data line shows the inverse, never a stale valid bit
    sdi = ~sdi;
    repeat (HALF) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// ---- testbench/dsis_init_core_tb_top.sv ----
// dsis_init_core_tb_top: self-checking bench of the start-up block
// assumes the host model drives the port; lock waits scaled to core cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((ex) !== (got)) begin \
  fail_count++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module dsis_init_core_tb_top;
  import dsis_pkg::*;
  // search is 1000 cycles, so the host waits a little longer
  localparam int LOCK_WAIT = 1100;
  logic core_clk, arst_n, input_data_clock, phase_loop_ok, rx_loop_ok;
  logic sclk, cs_n, sdi, sdo, sdo_oe, odc_en, irq, dclk_run, lsb;
  logic [9:0] fsc;
  logic [7:0] mode, rv;
  logic [1:0] div;
  logic [31:0] seed;
  logic [1:0] lock_fail;
  int fail_count, n_compared, w;
  int mdl [0:127];
  logic [6:0] rwq[$] = '{A_FSC_LO, A_FSC_HI, A_OPMODE, A_SKEW, A_DIVSEL,
    A_CM_A, A_CM_B, A_PT_A, A_PT_B, A_PT_C, A_PT_D};
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // link clock, unrelated in phase; stands still while dclk_run is low
  initial begin
    input_data_clock = 1'b0;
    #37;
    forever #100 input_data_clock = input_data_clock ^ dclk_run;
  end
  dsis_host_model #(.HALF(4)) host (.core_clk(core_clk), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
  dsis_init_core uut (.core_clk(core_clk), .arst_n(arst_n), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .input_data_clock(input_data_clock), .phase_loop_ok(phase_loop_ok),
    .rx_loop_ok(rx_loop_ok), .full_scale_current_setting(fsc),
    .converter_mode(mode), .divider_phase_select(div),
    .output_data_clock_en(odc_en), .irq(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
  endfunction
  task automatic stop_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic dflt();
    foreach (mdl[i]) mdl[i] = (i == 7) ? 2 : 0;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(lsb, 1'b0, a, d, rv);
    if (a == A_IFC) begin
      // reset bits return the others to defaults
      if ((d & 8'h24) != 0) dflt();
      mdl[0] = d;
      // either mirrored order bit picks lsb-first
      lsb = d[6] | d[1];
    end else if ((mdl[0] & 8'h24) == 0 &&
      a inside {[7'h06:7'h08], 7'h10, 7'h13, 7'h14, [7'h22:7'h29]}) begin
      mdl[a] = d;
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] ex);
    host.xfer(lsb, 1'b1, a, 8'h00, rv);
    `CHK("readback", ex, rv)
  endtask
  task automatic outs();
    `CHK("fsc", {mdl[7][1:0], mdl[6][7:0]}, fsc)
    `CHK("mode", mdl[8][7:0], mode)
    `CHK("div", mdl[20][7:6], div)
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    fail_count++;
    stop_test();
  end
  initial begin
    arst_n = 1'b0;
    phase_loop_ok = 1'b0;
    rx_loop_ok = 1'b0;
    dclk_run = 1'b1;
    lsb = 1'b0;
    seed = 32'h1917A6DC;
    lock_fail = 2'b00;
    fail_count = 0;
    n_compared = 0;
    dflt();
    repeat (12) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (6) @(negedge core_clk);
    outs();
    rd(A_FSC_HI, 8'h02);
    // random values through every plain register
    foreach (rwq[i]) begin
      seed = lfsr(seed);
      wr(rwq[i], seed[7:0]);
      rd(rwq[i], mdl[rwq[i]][7:0]);
      outs();
    end
    wr(7'h05, 8'hA5);
    rd(7'h05, 8'h00);
    wr(A_RXS, 8'hFF);
    rd(A_RXS, 8'h00);
    wr(A_PTS, 8'hFF);
    rd(A_PTS, 8'h00);
    // soft reset holds the others until cleared
    wr(A_IFC, 8'h20);
    outs();
    rd(A_IFC, 8'h20);
    wr(A_OPMODE, 8'h5A);
    rd(A_OPMODE, 8'h00);
    wr(A_IFC, 8'h00);
    wr(A_OPMODE, 8'h5A);
    rd(A_OPMODE, 8'h5A);
    wr(A_IFC, 8'h04);
    rd(A_OPMODE, 8'h00);
    wr(A_IFC, 8'h00);
    wr(A_IFC, 8'h42);
    wr(A_OPMODE, 8'hC3);
    rd(A_OPMODE, 8'hC3);
    outs();
    wr(A_IFC, 8'h00);
    rd(A_OPMODE, 8'hC3);
    wr(A_CM_A, 8'h0F);
    wr(A_CM_B, 8'h0F);
    rd(A_CM_B, 8'h0F);
    // phase tracking set-up, first attempt fails
    wr(A_PT_A, 8'h30);
    wr(A_PT_B, 8'h80);
    wr(A_PT_C, 8'h44);
    wr(A_PT_D, 8'h6C);
    for (int t = 0; t < 3; t++) begin
      wr(A_PT_E, 8'hCB);
      wr(A_PT_CTL, 8'h02);
      phase_loop_ok = (t != 0);
      wr(A_PT_CTL, 8'h03);
      rd(A_PTS, 8'h00);
      repeat (LOCK_WAIT) @(negedge core_clk);
      rd(A_PTS, {7'h00, t != 0});
      `CHK("odc_en", t != 0, odc_en)
      lock_fail[0] = lock_fail[0] | (t == 2 && rv !== 8'h01);
      if (t != 0) break;
    end
    `CHK("pt_fail", 1'b0, lock_fail[0])
    // receive set-up, divider advanced on retry
    wr(A_SKEW, 8'h72);
    for (int t = 0; t < 3 && !lock_fail[0]; t++) begin
      wr(A_CEN, 8'h00);
      wr(A_CEN, 8'h02);
      rx_loop_ok = (t != 0);
      wr(A_CEN, 8'h03);
      repeat (LOCK_WAIT) @(negedge core_clk);
      rd(A_RXS, (t != 0) ? 8'h09 : 8'h00);
      `CHK("irq", t != 0, irq)
      lock_fail[1] = lock_fail[1] | (t == 2 && rv !== 8'h09);
      if (t != 0) break;
      wr(A_DIVSEL, 8'h40);
      outs();
    end
    `CHK("rx_fail", 1'b0, lock_fail[1])
    // data clock stops: receive lock must fall
    dclk_run = 1'b0;
    w = 0;
    while (irq !== 1'b0 && w < 200) begin
      @(negedge core_clk);
      w++;
    end
    `CHK("irq_drop", 1'b1, w < 200)
    // let the idle data clock run past the checker's limit
    repeat (30) @(negedge core_clk);
    dclk_run = 1'b1;
    stop_test();
  end
endmodule
bind dsis_init_core dsis_init_core_assertions chk (.core_clk(core_clk),
  .arst_n(arst_n), .cs_n(cs_n), .sdo_oe(sdo_oe),
  .input_data_clock(input_data_clock), .phase_loop_ok(phase_loop_ok),
  .rx_loop_ok(rx_loop_ok),
  .full_scale_current_setting(full_scale_current_setting),
  .converter_mode(converter_mode),
  .output_data_clock_en(output_data_clock_en), .irq(irq));
`default_nettype wire
